// >>> design/branch_bitset_decode.v
// Decode and execute stage for relative jump, bit force and bit test skips.
// Assumes the core presents the fetched word and incremented PC at each Q1,
// and that data memory answers a read within the same clock in which memRd_r is high.
`timescale 1ns/1ps
`include "branch_bitset_decode_regs.vh"

module branch_bitset_decode #(
  parameter ADDR_W = 12,
  parameter PC_W   = 21
) (
  input  wire              clk,
  input  wire              rst,
  input  wire [15:0]       instrWord,
  input  wire [PC_W-1:0]   pcIncr,
  input  wire [3:0]        bankSelect,
  input  wire              extEnable,
  input  wire [ADDR_W-1:0] indexBase,
  input  wire [7:0]        memRdData,
  output reg  [3:0]        phase_r,
  output reg  [PC_W-1:0]   pcNext_r,
  output reg               pcLoad_r,
  output reg  [ADDR_W-1:0] memAddr_r,
  output reg               memRd_r,
  output reg  [7:0]        memWrData_r,
  output reg               memWr_r,
  output reg               fetchDiscard_r,
  output reg               nopCycle_r,
  output reg               indexed_r
);

  // ****************************************
  // States and operation classes
  // ****************************************
  localparam ST_EXEC = 2'b01;
  localparam ST_NOP  = 2'b10;

  localparam OP_NONE = 4'b0000;
  localparam OP_JUMP = 4'b0001;
  localparam OP_BSET = 4'b0010;
  localparam OP_SKC  = 4'b0100;
  localparam OP_SKS  = 4'b1000;

  reg [1:0]        state_r;
  reg [1:0]        state_nxt;
  reg [3:0]        op_r;
  reg [3:0]        opDecode;
  reg [15:0]       instr_r;
  reg [PC_W-1:0]   pcBase_r;
  reg [7:0]        data_r;
  reg              nopPending_r;

  wire [ADDR_W-1:0] resolvedAddr;
  wire              indexedMode;
  wire [2:0]        bitSel;
  wire [7:0]        bitMask;
  wire              bitValue;
  wire [PC_W-1:0]   jumpOffset;
  wire              skipTaken;

  // ****************************************
  // Address resolution
  // ****************************************
  file_addr_resolve #(
    .ADDR_W (ADDR_W)
  ) file_addr_resolve_inst (
    .fileAddr     (instrWord[`FLD_FILE_HI:0]),
    .bankFlag     (instrWord[`FLD_BANK_FLAG]),
    .bankSelect   (bankSelect),
    .extEnable    (extEnable),
    .indexBase    (indexBase),
    .resolvedAddr (resolvedAddr),
    .indexedMode  (indexedMode)
  );

  // ****************************************
  // Decode
  // ****************************************
  always @* begin
    case (instrWord[`FLD_OPC_HI:`FLD_OPC_LO])
      `OPC_RELATIVE_JUMP: opDecode = OP_JUMP;
      `OPC_BIT_FORCE:     opDecode = OP_BSET;
      `OPC_SKIP_ON_CLEAR: opDecode = OP_SKC;
      `OPC_SKIP_ON_SET:   opDecode = OP_SKS;
      default:            opDecode = OP_NONE;
    endcase
  end

  assign bitSel   = instr_r[`FLD_BIT_HI:`FLD_BIT_LO];
  assign bitValue = |(data_r & bitMask);

  // ****************************************
  // Bit mask, one select per data bit
  // ****************************************
  genvar bitIdx;
  generate
    for (bitIdx = 0; bitIdx < 8; bitIdx = bitIdx + 1) begin : gen_mask
      assign bitMask[bitIdx] = ({29'h0, bitSel} == bitIdx);
    end
  endgenerate

  // Offset counts words, so doubling lands on byte addresses
  assign jumpOffset = {{(PC_W-12){instr_r[`FLD_OFS_HI]}},
                       instr_r[`FLD_OFS_HI:0], 1'b0};
  assign skipTaken = ((op_r == OP_SKC) && !bitValue) ||
                     ((op_r == OP_SKS) && bitValue);

  // ****************************************
  // Cycle sequencing
  // ****************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_EXEC: begin
        if (phase_r == `PHASE_Q4 && nopPending_r) begin
          state_nxt = ST_NOP;
        end
      end
      ST_NOP: begin
        if (phase_r == `PHASE_Q4) begin
          state_nxt = ST_EXEC;
        end
      end
      default: state_nxt = ST_EXEC;
    endcase
  end

  // ****************************************
  // Phase ring and cycle state
  // ****************************************
  always @(posedge clk) begin
    if (rst) begin
      phase_r    <= `PHASE_Q1;
      state_r    <= ST_EXEC;
      nopCycle_r <= 1'b0;
    end else begin
      // Four-phase enable ring, one phase per clock
      case (phase_r)
        `PHASE_Q1, `PHASE_Q2, `PHASE_Q3, `PHASE_Q4: begin
          phase_r <= {phase_r[2:0], phase_r[3]};
        end
        // A corrupted ring restarts at Q1 instead of stalling for good
        default: begin
          phase_r <= `PHASE_Q1;
        end
      endcase
      state_r    <= state_nxt;
      nopCycle_r <= (state_nxt == ST_NOP);
    end
  end

  // ****************************************
  // Decode registers and datapath
  // ****************************************
  always @(posedge clk) begin
    if (rst) begin
      op_r           <= OP_NONE;
      instr_r        <= 16'h0000;
      pcBase_r       <= `RST_PC;
      data_r         <= `RST_BYTE;
      nopPending_r   <= 1'b0;
      pcNext_r       <= `RST_PC;
      pcLoad_r       <= 1'b0;
      memAddr_r      <= `RST_ADDR;
      memRd_r        <= 1'b0;
      memWrData_r    <= `RST_BYTE;
      memWr_r        <= 1'b0;
      fetchDiscard_r <= 1'b0;
      indexed_r      <= 1'b0;
    end else begin
      pcLoad_r       <= 1'b0;
      memRd_r        <= 1'b0;
      memWr_r        <= 1'b0;
      fetchDiscard_r <= 1'b0;
      case (phase_r)
        `PHASE_Q1: begin
          nopPending_r <= 1'b0;
          if (state_r == ST_EXEC) begin
            op_r      <= opDecode;
            instr_r   <= instrWord;
            pcBase_r  <= pcIncr;
            memAddr_r <= resolvedAddr;
            indexed_r <= indexedMode;
            memRd_r   <= (opDecode != OP_NONE) && (opDecode != OP_JUMP);
          end else begin
            // Discarded word is never decoded
            op_r <= OP_NONE;
          end
        end
        `PHASE_Q2: begin
          data_r <= memRdData;
        end
        `PHASE_Q3: begin
          if (op_r == OP_BSET) begin
            memWrData_r <= data_r | bitMask;
            memWr_r     <= 1'b1;
          end
          if (op_r == OP_JUMP) begin
            pcNext_r     <= pcBase_r + jumpOffset;
            pcLoad_r     <= 1'b1;
            fetchDiscard_r <= 1'b1;
            nopPending_r <= 1'b1;
          end
          if (skipTaken) begin
            fetchDiscard_r <= 1'b1;
            nopPending_r   <= 1'b1;
          end
        end
        `PHASE_Q4: begin
          op_r <= op_r;
        end
        default: begin
          // Ring is being restarted; nothing half-done may execute
          op_r <= OP_NONE;
        end
      endcase
    end
  end

endmodule

// >>> design/branch_bitset_decode_regs.vh
// Constants for the relative jump, bit force and bit test decode block.
// Assumes the including file works on 16-bit instruction words.
`ifndef BRANCH_BITSET_DECODE_REGS_VH
`define BRANCH_BITSET_DECODE_REGS_VH

// ****************************************
// Opcode prefixes, instr[15:12]
// ****************************************
`define OPC_RELATIVE_JUMP   4'hD
`define OPC_BIT_FORCE       4'h8
`define OPC_SKIP_ON_CLEAR   4'hB
`define OPC_SKIP_ON_SET     4'hA

// ****************************************
// Field positions
// ****************************************
`define FLD_OPC_HI          15
`define FLD_OPC_LO          12
`define FLD_OFS_HI          10
`define FLD_BIT_HI          11
`define FLD_BIT_LO          9
`define FLD_BANK_FLAG       8
`define FLD_FILE_HI         7

// ****************************************
// Addressing limits
// ****************************************
`define INDEXED_LIMIT       8'h5F
`define ACCESS_SPLIT        8'h60
`define ACCESS_HIGH_BANK    4'hF

// ****************************************
// Reset values and phase timing
// ****************************************
`define PHASE_Q1            4'h1
`define PHASE_Q2            4'h2
`define PHASE_Q3            4'h4
`define PHASE_Q4            4'h8
`define PHASE_COUNT         4
`define RST_PC              21'h000000
`define RST_ADDR            12'h000
`define RST_BYTE            8'h00

`endif

// >>> design/file_addr_resolve.v
// File register address resolution for byte and bit oriented operands.
// Assumes bank select and index base are stable during the decode phase.
`timescale 1ns/1ps
`include "branch_bitset_decode_regs.vh"

module file_addr_resolve #(
  parameter ADDR_W = 12
) (
  input  wire [7:0]        fileAddr,
  input  wire              bankFlag,
  input  wire [3:0]        bankSelect,
  input  wire              extEnable,
  input  wire [ADDR_W-1:0] indexBase,
  output reg  [ADDR_W-1:0] resolvedAddr,
  output reg               indexedMode
);

  always @* begin
    indexedMode  = 1'b0;
    resolvedAddr = {ADDR_W{1'b0}};
    if (bankFlag) begin
      resolvedAddr = {bankSelect, fileAddr};
    end else if (extEnable && (fileAddr <= `INDEXED_LIMIT)) begin
      // Literal offset from the index base replaces the access bank
      indexedMode  = 1'b1;
      resolvedAddr = indexBase + {{(ADDR_W-8){1'b0}}, fileAddr};
    end else if (fileAddr < `ACCESS_SPLIT) begin
      resolvedAddr = {4'h0, fileAddr};
    end else begin
      resolvedAddr = {`ACCESS_HIGH_BANK, fileAddr};
    end
  end

endmodule

// >>> test/branch_bitset_decode_monitor.sv
// Port checker for branch_bitset_decode.
// Assumes the default 12-bit address and 21-bit PC widths.
`timescale 1ns/1ps
module branch_bitset_decode_monitor (
  input wire        clk,
  input wire        rst,
  input wire [15:0] instrWord,
  input wire [20:0] pcIncr,
  input wire [3:0]  bankSelect,
  input wire        extEnable,
  input wire [11:0] indexBase,
  input wire [7:0]  memRdData,
  input wire [3:0]  phase_r,
  input wire [20:0] pcNext_r,
  input wire        pcLoad_r,
  input wire [11:0] memAddr_r,
  input wire        memRd_r,
  input wire [7:0]  memWrData_r,
  input wire        memWr_r,
  input wire        fetchDiscard_r,
  input wire        nopCycle_r,
  input wire        indexed_r
);
  wire        take = phase_r == 4'h1 && !nopCycle_r;
  wire [3:0]  op   = instrWord[15:12];
  wire [7:0]  f    = instrWord[7:0];
  wire        mem  = take && (op == 4'h8 || op[3:1] == 3'b101);
  wire        idx  = extEnable && !instrWord[8] && f <= 8'h5F;
  wire [11:0] bank = instrWord[8] ? {bankSelect, f} : {f < 8'h60 ? 4'h0 : 4'hF, f};
  wire [11:0] ofs  = indexBase + {4'h0, f};
  // skip and setv are read in Q2, so they lean on the word being held all cycle
  wire        skip = memRdData[instrWord[11:9]] ^ instrWord[12];
  wire [7:0]  setv = memRdData | 8'h01 << instrWord[11:9];
  wire [20:0] tgt  = pcIncr + {{9{instrWord[10]}}, instrWord[10:0], 1'b0};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****
  // Properties
  // ****
  sequence s_nop; nopCycle_r [*4]; endsequence
  sequence s_rmw; memRd_r ##2 memWr_r; endsequence
  property p_dec; pcLoad_r |-> $past(take, 3) && $past(op, 3) == 4'hD; endproperty
  a_dec: assert property (p_dec) else $error("load without jump");
  property p_tgt; pcLoad_r |-> pcNext_r == $past(tgt, 3); endproperty
  a_tgt: assert property (p_tgt) else $error("bad jump target");
  property p_tim; take && op == 4'hD |-> ##3 pcLoad_r && fetchDiscard_r ##1 s_nop; endproperty
  a_tim: assert property (p_tim) else $error("bad jump timing");
  property p_set; take && op == 4'h8 |-> ##1 s_rmw ##0 memWrData_r == $past(setv, 2); endproperty
  a_set: assert property (p_set) else $error("bad bit force");
  property p_bnk; mem && !idx |=> !indexed_r && memAddr_r == $past(bank); endproperty
  a_bnk: assert property (p_bnk) else $error("bad bank address");
  property p_idx; mem && idx |=> indexed_r && memAddr_r == $past(ofs); endproperty
  a_idx: assert property (p_idx) else $error("bad indexed address");
  property p_skp; take && op[3:1] == 3'b101 |-> ##3 fetchDiscard_r == $past(skip, 2); endproperty
  a_skp: assert property (p_skp) else $error("bad skip");
  property p_nop; nopCycle_r |-> !memRd_r && !memWr_r && !pcLoad_r; endproperty
  a_nop: assert property (p_nop) else $error("work in no-op cycle");
endmodule

bind branch_bitset_decode branch_bitset_decode_monitor branch_bitset_decode_monitor_inst (
  .clk(clk), .rst(rst), .instrWord(instrWord), .pcIncr(pcIncr), .bankSelect(bankSelect),
  .extEnable(extEnable), .indexBase(indexBase), .memRdData(memRdData), .phase_r(phase_r),
  .pcNext_r(pcNext_r), .pcLoad_r(pcLoad_r), .memAddr_r(memAddr_r), .memRd_r(memRd_r),
  .memWrData_r(memWrData_r), .memWr_r(memWr_r), .fetchDiscard_r(fetchDiscard_r),
  .nopCycle_r(nopCycle_r), .indexed_r(indexed_r));

// >>> test/branch_bitset_decode_tb_top.sv
// Self-checking bench for branch_bitset_decode.
// Assumes design/ is on the include path.
`timescale 1ns/1ps
module branch_bitset_decode_tb_top;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [15:0] instrWord = 16'h0000;
  reg  [20:0] pcIncr = 21'h001000;
  reg  [3:0]  bankSelect = 4'h0;
  reg         extEnable = 1'b0;
  reg  [11:0] indexBase = 12'h100;
  reg  [7:0]  memRdData = 8'h00;
  wire [3:0]  phase_r;
  wire [20:0] pcNext_r;
  wire [11:0] memAddr_r;
  wire [7:0]  memWrData_r;
  wire        pcLoad_r, memRd_r, memWr_r, fetchDiscard_r, nopCycle_r, indexed_r;
  integer     n_mismatch = 0;
  integer     samples_checked = 0;
  integer     i;
  always #12.5 clk = ~clk;
  branch_bitset_decode branch_bitset_decode_inst (
    .clk(clk), .rst(rst), .instrWord(instrWord), .pcIncr(pcIncr), .bankSelect(bankSelect),
    .extEnable(extEnable), .indexBase(indexBase), .memRdData(memRdData), .phase_r(phase_r),
    .pcNext_r(pcNext_r), .pcLoad_r(pcLoad_r), .memAddr_r(memAddr_r), .memRd_r(memRd_r),
    .memWrData_r(memWrData_r), .memWr_r(memWr_r), .fetchDiscard_r(fetchDiscard_r),
    .nopCycle_r(nopCycle_r), .indexed_r(indexed_r));
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: %0h vs %0h", $time, seen, exp);
      end
    end
  endtask
  // ****
  // Scenarios
  // ****
  // Issues at Q1, returns in Q4; waits out any forced no-op cycle first
  task run(input [15:0] w, input [7:0] rd, input [3:0] bs, input ex);
    begin
      #1;
      while (phase_r !== 4'h8 || fetchDiscard_r !== 1'b0) begin
        @(posedge clk);
        #1;
      end
      @(posedge clk);
      instrWord <= w;
      memRdData <= rd;
      bankSelect <= bs;
      extEnable <= ex;
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  task t_jump;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        run({5'h1A, i == 0 ? 11'h3FF : i == 1 ? 11'h400 : 11'h7FF}, 8'h00, 4'h0, 1'b0);
        chk({pcLoad_r, fetchDiscard_r, pcNext_r},
            {2'b11, i == 0 ? 21'h0017FE : i == 1 ? 21'h000800 : 21'h000FFE});
        @(posedge clk);
        #1;
        chk(nopCycle_r, 1'b1);
      end
      run(16'hE3FF, 8'h00, 4'h0, 1'b0);
      chk(pcLoad_r, 1'b0);
      $display("jump test done");
    end
  endtask
  task t_force;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        run({4'h8, i[2:0], 1'b1, 8'h25}, 8'h0A, 4'h3, 1'b0);
        chk(memAddr_r, 12'h325);
        chk({memWr_r, memWrData_r}, {1'b1, 8'h0A | 8'h01 << i[2:0]});
      end
      run(16'h8E5F, 8'h0A, 4'h3, 1'b0);
      chk({memAddr_r, memWrData_r}, {12'h05F, 8'h8A});
      run(16'h8060, 8'h0A, 4'h3, 1'b0);
      chk(memAddr_r, 12'hF60);
      $display("bit force test done");
    end
  endtask
  task t_index;
    begin
      run(16'h825F, 8'h00, 4'h3, 1'b1);
      chk({indexed_r, memAddr_r}, {1'b1, 12'h15F});
      run(16'h8260, 8'h00, 4'h3, 1'b1);
      chk({indexed_r, memAddr_r}, {1'b0, 12'hF60});
      run(16'h8310, 8'h00, 4'h3, 1'b1);
      chk({indexed_r, memAddr_r}, {1'b0, 12'h310});
      $display("indexed test done");
    end
  endtask
  task t_skip;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        run({i[1] ? 4'hB : 4'hA, 12'h940}, i[0] ? 8'h10 : 8'hEF, 4'h2, 1'b0);
        chk({memWr_r, fetchDiscard_r}, {1'b0, i[0] ^ i[1]});
        @(posedge clk);
        #1;
        chk(nopCycle_r, i[0] ^ i[1]);
      end
      $display("skip test done");
    end
  endtask
  task results;
    begin
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_jump;
    t_force;
    t_index;
    t_skip;
    results;
  end
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    results;
  end
endmodule
